// file: pfcg_pkg.sv
// constants and carrier types for the pwm forced-cutoff port gate
// Operation
// R1: gating applies only to pins set as outputs
// R2: timer unused: pins drive selected function
// R3: timer used, enable clear: pins high impedance
// R4: both set: drive if cutoff high, else float
// R5: cutoff pin low clears motor output enable
// R6: input path never touched by gating controls
package pfcg_pkg;

	// pin count of the cutoff group: four of group a, b0 and b1
	localparam int PIN_COUNT = 6;
	localparam int PIN_MAX   = 16;

	// control write field positions
	localparam int CTRL_USE_POS = 0;
	localparam int CTRL_EN_POS  = 1;
	localparam int CTRL_WIDTH   = 2;

	// reset values: timer not used, output disabled
	localparam logic RST_USE = 1'h0;
	localparam logic RST_EN  = 1'h0;

	// cutoff pin level that forces the pins off
	localparam logic CUTOFF_ACTIVE = 1'h0;

	// control register contents, part of inverter_control_zero
	typedef struct packed {
		logic motor_output_enable;
		logic motor_timer_use;
	} pfcg_ctrl_t;

	// one pad's drive pair
	typedef struct packed {
		logic drive;
		logic level;
	} pfcg_pad_t;

endpackage

// file: pfcg_gate.sv
// output gating of the six forced-cutoff port pins
`timescale 1ns/10ps
module pfcg_gate #(
	parameter int PINS = pfcg_pkg::PIN_COUNT
) (
	// clock, reset, enable
	input  wire logic                 mclk_i,
	input  wire logic                 rstn_i,
	input  wire logic                 ce_i,
	// software access to the inverter control bits
	input  wire logic                 ctrl_we_i,
	input  wire pfcg_pkg::pfcg_ctrl_t ctrl_wdata_i,
	// cutoff pin level, active low
	input  wire logic                 cutoff_n_i,
	// per-pin configuration, function data and pad level
	input  wire logic [PINS-1:0]      out_cfg_i,
	input  wire logic [PINS-1:0]      func_data_i,
	input  wire logic [PINS-1:0]      pad_in_i,
	// pad drive
	output logic      [PINS-1:0]      pad_out_o,
	output logic      [PINS-1:0]      pad_oe_o,
	// input path towards the port and peripherals
	output logic      [PINS-1:0]      port_in_o,
	// status
	output pfcg_pkg::pfcg_ctrl_t      ctrl_o,
	output logic                      cutoff_active_o
);

	if (PINS < 1 || PINS > pfcg_pkg::PIN_MAX) begin : g_bad_pins
		$error("pfcg_gate: PINS out of range");
	end

	// gate decision for one pin
	function automatic pfcg_pkg::pfcg_pad_t gate_pin(
		input logic cfg_out,
		input logic data,
		input logic use_timer,
		input logic out_en,
		input logic cutoff_n
	);
		pfcg_pkg::pfcg_pad_t p;
		p.drive = 1'h0;
		p.level = 1'h0;
		if (cfg_out) begin
			if (!use_timer) begin
				p.drive = 1'h1;
			end else if (out_en && cutoff_n != pfcg_pkg::CUTOFF_ACTIVE) begin
				p.drive = 1'h1;
			end
			p.level = p.drive ? data : 1'h0;
		end
		return p;
	endfunction

	pfcg_pkg::pfcg_ctrl_t ctrl;
	pfcg_pkg::pfcg_ctrl_t next_ctrl;
	logic                 cutoff_hit;

	assign cutoff_hit = (cutoff_n_i == pfcg_pkg::CUTOFF_ACTIVE);

	// control bits; cutoff beats a write so a low level never lets the output enable be set
	always_comb begin
		next_ctrl = ctrl;
		if (ctrl_we_i) begin
			next_ctrl = ctrl_wdata_i;
		end
		// R5: cutoff clears enable
		if (cutoff_hit) begin
			next_ctrl.motor_output_enable = 1'h0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			ctrl <= '{motor_output_enable: pfcg_pkg::RST_EN,
			          motor_timer_use:     pfcg_pkg::RST_USE};
		end else if (ce_i) begin
			ctrl <= next_ctrl;
		end
	end

	logic [PINS-1:0] next_pad_out;
	logic [PINS-1:0] next_pad_oe;
	logic [PINS-1:0] next_port_in;
	logic            next_cutoff_active;
	pfcg_pkg::pfcg_pad_t pad_sel;

	// pad gating uses the live cutoff level so with the timer used the output pins float one edge after it falls
	always_comb begin
		next_pad_out = '0;
		next_pad_oe  = '0;
		pad_sel      = '{drive: 1'h0, level: 1'h0};
		for (int i = 0; i < PINS; i++) begin
			// R1: R2: R3: R4: per-pin gate
			pad_sel = gate_pin(out_cfg_i[i], func_data_i[i], ctrl.motor_timer_use,
			                   ctrl.motor_output_enable, cutoff_n_i);
			next_pad_out[i] = pad_sel.level;
			next_pad_oe[i]  = pad_sel.drive;
		end
		// R6: input path untouched
		next_port_in       = pad_in_i;
		next_cutoff_active = ctrl.motor_timer_use & ~ctrl.motor_output_enable;
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			pad_out_o       <= '0;
			pad_oe_o        <= '0;
			port_in_o       <= '0;
			ctrl_o          <= '{motor_output_enable: pfcg_pkg::RST_EN,
			                     motor_timer_use:     pfcg_pkg::RST_USE};
			cutoff_active_o <= 1'h0;
		end else if (ce_i) begin
			pad_out_o       <= next_pad_out;
			pad_oe_o        <= next_pad_oe;
			port_in_o       <= next_port_in;
			ctrl_o          <= next_ctrl;
			cutoff_active_o <= next_cutoff_active;
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);

	// reset held in the antecedents: a release edge still has its outputs in reset
	sequence s_cutoff_low;
		rstn_i && ce_i && !cutoff_n_i;
	endsequence

	sequence s_stays_off;
		rstn_i && ce_i && !ctrl_we_i;
	endsequence

	sequence s_write_in_cutoff;
		rstn_i && ce_i && ctrl_we_i && !cutoff_n_i;
	endsequence

	sequence s_plain_write;
		rstn_i && ce_i && ctrl_we_i && cutoff_n_i;
	endsequence

	// R1: input-configured pins never driven
	a_input_not_driven: assert property ( // R1
		rstn_i && ce_i |=> ((pad_oe_o & ~$past(out_cfg_i)) == '0))
		else $error("pin driven while set as input");

	// R2: timer unused drives function
	a_unused_drives: assert property ( // R2
		rstn_i && ce_i && !ctrl.motor_timer_use |=>
			pad_oe_o == $past(out_cfg_i) && pad_out_o == ($past(func_data_i) & $past(out_cfg_i)))
		else $error("function not driven with timer unused");

	// R3: enable clear floats pins
	a_disabled_float: assert property ( // R3
		rstn_i && ce_i && ctrl.motor_timer_use && !ctrl.motor_output_enable |=> pad_oe_o == '0)
		else $error("pins driven with motor output disabled");

	// R4: both set drives when cutoff high
	a_enabled_drives: assert property ( // R4
		rstn_i && ce_i && ctrl.motor_timer_use && ctrl.motor_output_enable && cutoff_n_i |=>
			pad_oe_o == $past(out_cfg_i) &&
			pad_out_o == ($past(func_data_i) & $past(out_cfg_i)))
		else $error("pins not driven with cutoff high");

	// R4: cutoff low floats pins
	a_cutoff_floats: assert property ( // R4
		s_cutoff_low and (ctrl.motor_timer_use == 1'h1) |=> pad_oe_o == '0)
		else $error("pins driven while cutoff low");

	// R5: enable cleared and held
	a_enable_cleared: assert property ( // R5
		s_cutoff_low ##1 s_stays_off [*2] |-> !ctrl.motor_output_enable)
		else $error("output enable survives cutoff");

	// R5: float persists after cutoff returns high
	a_float_persists: assert property ( // R5
		s_cutoff_low ##1 (s_stays_off and ctrl.motor_timer_use) |=> pad_oe_o == '0)
		else $error("pins resumed drive after cutoff without rewrite");

	// R6: input path mirrors pad
	a_input_path: assert property ( // R6
		rstn_i && ce_i |=> port_in_o == $past(pad_in_i))
		else $error("input path altered by gating");

	// R3: status marks floated pins
	a_status_flag: assert property ( // R3
		rstn_i && ce_i |=>
			cutoff_active_o == ($past(ctrl.motor_timer_use) & ~$past(ctrl.motor_output_enable)))
		else $error("cutoff status wrong");

	// reset clears state and outputs
	a_reset_clears: assert property (disable iff (1'h0)
		!rstn_i |=> ctrl == '0 && ctrl_o == '0 && pad_oe_o == '0 && pad_out_o == '0 &&
			port_in_o == '0 && !cutoff_active_o)
		else $error("state not cleared by reset");

	// enable low freezes everything
	a_freeze_holds: assert property (
		rstn_i && !ce_i |=> $stable(ctrl) && $stable(pad_oe_o) && $stable(pad_out_o) &&
			$stable(port_in_o) && $stable(ctrl_o) && $stable(cutoff_active_o))
		else $error("state moved with clock enable low");

	// R5: clear beats write
	a_clear_beats_write: assert property ( // R5
		s_write_in_cutoff |=> !ctrl.motor_output_enable &&
			ctrl.motor_timer_use == $past(ctrl_wdata_i.motor_timer_use))
		else $error("write overrode cutoff clear");

	// write lands outside cutoff
	a_write_lands: assert property (
		s_plain_write |=> ctrl == $past(ctrl_wdata_i))
		else $error("control write lost");

	// R5: enable held until rewrite
	a_enable_held: assert property ( // R5
		rstn_i && ce_i && !ctrl.motor_output_enable && !ctrl_we_i |=>
			!ctrl.motor_output_enable)
		else $error("output enable set without a write");

	// undriven pads carry zero
	a_undriven_low: assert property (
		rstn_i && ce_i |=> (pad_out_o & ~pad_oe_o) == '0)
		else $error("undriven pad carries data");

endmodule

// file: pfcg_motor_drv.sv
// motor driver side of the cutoff pins, resolves the pad wire level
`timescale 1ns/10ps
module pfcg_motor_drv (
	// clock
	input  wire logic       mclk_i,
	// pad drive from the gate
	input  wire logic [5:0] pad_out_i,
	input  wire logic [5:0] pad_oe_i,
	// resolved wire level
	output logic      [5:0] pad_in_o
);
	logic [5:0] last = 6'h00;
	// released pins show the inverse of the last driven level, never a held copy
	assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ~last);
	always_ff @(posedge mclk_i) begin
		last <= (pad_oe_i & pad_out_i) | (~pad_oe_i & last);
	end
endmodule

// file: pfcg_gate_tb.sv
// self-checking bench for the cutoff port gate
`timescale 1ns/10ps
module pfcg_gate_tb;
	logic                 mclk_i       = 1'h0;
	logic                 rstn_i       = 1'h0;
	logic                 ce_i         = 1'h1;
	logic                 ctrl_we_i    = 1'h0;
	pfcg_pkg::pfcg_ctrl_t ctrl_wdata_i = 2'h0;
	logic                 cutoff_n_i   = 1'h1;
	logic [5:0]           out_cfg_i    = 6'h00;
	logic [5:0]           func_data_i  = 6'h2D;
	logic [5:0]           pad_in_i;
	logic [5:0]           pad_out_o;
	logic [5:0]           pad_oe_o;
	logic [5:0]           port_in_o;
	pfcg_pkg::pfcg_ctrl_t ctrl_o;
	logic                 cutoff_active_o;
	logic [1:0]           ctrl_m       = 2'h0;
	logic [5:0]           oe_m;
	logic [20:0]          exp_m;
	int                   error_cnt    = 0;
	int                   n_checks     = 0;
	always #20 mclk_i = ~mclk_i;
	pfcg_gate uut (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i), .ctrl_we_i(ctrl_we_i),
		.ctrl_wdata_i(ctrl_wdata_i), .cutoff_n_i(cutoff_n_i), .out_cfg_i(out_cfg_i),
		.func_data_i(func_data_i), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
		.pad_oe_o(pad_oe_o), .port_in_o(port_in_o), .ctrl_o(ctrl_o),
		.cutoff_active_o(cutoff_active_o));
	pfcg_motor_drv drv (.mclk_i(mclk_i), .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
		.pad_in_o(pad_in_i));
	task automatic cmp(input logic [20:0] got, input logic [20:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// one setting applied, left to settle, then every output compared
	task automatic run(input logic we, input logic [1:0] c, input logic cut,
			input logic [5:0] cfg);
		@(posedge mclk_i);
		ctrl_we_i    <= we;
		ctrl_wdata_i <= c;
		cutoff_n_i   <= cut;
		out_cfg_i    <= cfg;
		func_data_i  <= ~func_data_i;
		@(posedge mclk_i);
		ctrl_we_i <= 1'h0;
		repeat (2) @(posedge mclk_i);
		#1;
		// frozen run: model state and expectation carry over unchanged
		if (ce_i) begin
			if (we)
				ctrl_m = c;
			if (!cut)
				ctrl_m[1] = 1'h0;
			oe_m  = cfg & (ctrl_m[0] ? {6{ctrl_m[1] & cut}} : 6'h3F);
			exp_m = {ctrl_m[0] & ~ctrl_m[1], ctrl_m, oe_m, oe_m & func_data_i, pad_in_i};
		end
		cmp({cutoff_active_o, ctrl_o, pad_oe_o, pad_out_o, port_in_o}, exp_m);
	endtask
	task automatic print_verdict;
		if (error_cnt == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#20000;
		error_cnt++;
		print_verdict();
	end
	initial begin
		repeat (20) @(posedge mclk_i);
		rstn_i <= 1'h1;
		run(1'h1, 2'h0, 1'h1, 6'h3F); // timer unused
		run(1'h0, 2'h0, 1'h0, 6'h15); // cutoff ignored
		run(1'h1, 2'h1, 1'h1, 6'h3F); // enable clear
		run(1'h1, 2'h3, 1'h1, 6'h3C); // cutoff high
		@(posedge mclk_i);
		ce_i <= 1'h0;
		run(1'h1, 2'h0, 1'h1, 6'h15); // held while frozen
		@(posedge mclk_i);
		ce_i <= 1'h1;
		run(1'h0, 2'h3, 1'h0, 6'h3C); // cutoff low
		run(1'h0, 2'h3, 1'h1, 6'h3C); // stays floated
		run(1'h1, 2'h3, 1'h0, 6'h3F); // clear beats write
		run(1'h1, 2'h3, 1'h1, 6'h00); // inputs only
		run(1'h1, 2'h1, 1'h0, 6'h0A); // input path
		@(posedge mclk_i);
		rstn_i <= 1'h0;
		repeat (2) @(posedge mclk_i);
		rstn_i <= 1'h1;
		ctrl_m = 2'h0;
		run(1'h0, 2'h3, 1'h1, 6'h3F); // after mid-run reset
		print_verdict();
	end
endmodule
